// ---- gtu_pin_model.sv ----
`timescale 1ns/1ps
module gtu_pin_model (
   // clock
   input wire logic clk_i,
   // pins toward the timer unit
   output logic [4:0] tin_o,
   output logic [2:0] dir_o,
   output logic core2_dir_o,
   output logic capture_input_pin_o
);
   int pos = 0;
   initial begin
      tin_o = 5'h00;
      dir_o = 3'h0;
      core2_dir_o = 1'b0;
      capture_input_pin_o = 1'b0;
   end
   // held gate and direction levels
   task automatic set_lvl(input logic [4:0] t, input logic [2:0] d, input logic c);
      @(posedge clk_i);
      tin_o <= t;
      dir_o <= d;
      core2_dir_o <= c;
   endtask
   // one event, each level four clocks; index 5 is the capture pin
   task automatic pulse(input int idx);
      repeat (2) begin
         @(posedge clk_i);
         if (idx == 5) begin
            capture_input_pin_o <= ~capture_input_pin_o;
         end else begin
            tin_o[idx] <= ~tin_o[idx];
         end
         repeat (3) @(posedge clk_i);
      end
   endtask
   // gray-coded sensor step on core one count and direction pins
   task automatic step(input int d);
      logic [1:0] g;
      pos = (pos + d) & 3;
      g = (pos == 0) ? 2'b00 : (pos == 1) ? 2'b10 : (pos == 2) ? 2'b11 : 2'b01;
      @(posedge clk_i);
      tin_o[1] <= g[1];
      dir_o[1] <= g[0];
      repeat (4) @(posedge clk_i);
   endtask
endmodule

// ---- gtu_pkg.sv ----
// Overview of operation
// - five 16-bit timers in two groups
// - group one timers have four modes
// - timer mode counts prescaled system clock
// - counter mode counts input pin edges
// - gated mode counts only at gate level
// - group one resolution four clock cycles
// - direction from software or direction pin
// - quadrature A/B inputs drive position count
// - core one latch toggles on overflow, output
// - core one latch clocks auxiliary timers
// - auxiliary timer as capture/reload stops counting
// - capture copies core one on pin edge
// - reload core one on pin or latch edge
// - opposite latch edges alternate reload values
// - group two resolution two clock cycles
// - group two prescaled or external clocking
// - core two latch toggles, clocks aux two
// - core two overflow clocks compare, reloads
// - capture aux two, optional clear after
// - core one pins may trigger capture
// - aux two direction is software only
package gtu_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int NUM_TMR = 5;
   localparam int PIN_W = 10;
   // timer indices
   localparam int IDX_AUX_A = 0;
   localparam int IDX_CORE1 = 1;
   localparam int IDX_AUX_B = 2;
   localparam int IDX_AUX2 = 3;
   localparam int IDX_CORE2 = 4;
   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [7:0] CTRL_BASE = 8'h00;
   localparam logic [7:0] VAL_BASE = 8'h20;
   localparam logic [7:0] CAPTURE_RELOAD_REGISTER_OFS = 8'h40;
   localparam logic [7:0] STAT_OFS = 8'h44;
   localparam logic [7:0] LATCH_OFS = 8'h48;
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [15:0] VAL_RST = 16'h0000;
   // ---------------------------------------------------------------
   // control fields
   // ---------------------------------------------------------------
   localparam int F_PRE_LSB = 0;
   localparam int F_PRE_MSB = 2;
   localparam int F_MODE_LSB = 3;
   localparam int F_MODE_MSB = 4;
   localparam int F_EDGE_LSB = 5;
   localparam int F_EDGE_MSB = 6;
   localparam int F_GATE = 7;
   localparam int F_RUN = 8;
   localparam int F_DOWN = 9;
   localparam int F_EXTDIR = 10;
   localparam int F_TOUT = 11;
   localparam int F_FUNC_LSB = 12;
   localparam int F_FUNC_MSB = 13;
   localparam int F_LSRC = 14;
   localparam int F_RLD_LATCH = 15;
   // aux two / core two specific
   localparam int F_CLR = 11;
   localparam int F_CAP_PIN = 12;
   localparam int F_CAP_T1IN = 13;
   localparam int F_CAP_T1DIR = 15;
   localparam int F_RLD_CR = 12;
   localparam int F_CEDGE_LSB = 13;
   localparam int F_CEDGE_MSB = 14;
   // status bits
   localparam int S_CAP_A = 5;
   localparam int S_CAP_B = 6;
   localparam int S_CAP_CR = 7;
   localparam int STAT_W = 8;
   // prescaler base shifts: 4 and 2 system clocks
   localparam int G1_BASE_SH = 2;
   localparam int G2_BASE_SH = 1;
   localparam int PRE_W = 10;

   typedef enum logic [1:0] {
      GTU_MODE_TIMER = 2'h0,
      GTU_MODE_GATED = 2'h1,
      GTU_MODE_COUNT = 2'h2,
      GTU_MODE_INCR = 2'h3
   } gtu_mode_t;

   typedef enum logic [1:0] {
      GTU_FN_NORMAL = 2'h0,
      GTU_FN_RELOAD = 2'h1,
      GTU_FN_CAPTURE = 2'h2
   } gtu_func_t;
endpackage

// ---- gtu_timer_unit.sv ----
`timescale 1ns/1ps
module gtu_timer_unit (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // register port
   input wire logic [7:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   // pins
   input wire logic [4:0] tin_i,
   input wire logic [2:0] g1_dir_i,
   input wire logic core2_dir_i,
   input wire logic capture_input_pin_i,
   // outputs
   output logic core1_tout_o,
   output logic core2_tout_o,
   output logic cmp_clk_o
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic [15:0] ctrl_r [gtu_pkg::NUM_TMR];
   logic [15:0] val_r [gtu_pkg::NUM_TMR];
   logic [15:0] val_nxt [gtu_pkg::NUM_TMR];
   logic [15:0] capture_reload_register_r;
   logic [15:0] capture_reload_register_nxt;
   logic [gtu_pkg::STAT_W-1:0] stat_r;
   logic [gtu_pkg::STAT_W-1:0] stat_set;
   logic latch1_r;
   logic latch2_r;
   logic [gtu_pkg::PRE_W-1:0] pre_r;
   logic [gtu_pkg::PIN_W-1:0] sync1_r;
   logic [gtu_pkg::PIN_W-1:0] sync2_r;
   logic [gtu_pkg::PIN_W-1:0] prev_r;
   logic [gtu_pkg::NUM_TMR-1:0] ovf;
   logic l1_rise;
   logic l1_fall;
   logic l2_ev;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic edge_hit(input logic [1:0] sel, input logic prv, input logic cur);
      edge_hit = (sel[0] & ~prv & cur) | (sel[1] & prv & ~cur);
   endfunction

   function automatic logic pre_hit(input logic [gtu_pkg::PRE_W-1:0] cnt,
                                    input logic [2:0] sel, input int base);
      logic [gtu_pkg::PRE_W-1:0] mask;
      mask = gtu_pkg::PRE_W'((1 << (base + int'(sel))) - 1);
      pre_hit = ((cnt & mask) == mask);
   endfunction

   // core timers evaluated before the auxiliaries they clock
   function automatic int order(input int k);
      case (k)
         0: order = gtu_pkg::IDX_CORE1;
         1: order = gtu_pkg::IDX_AUX_A;
         2: order = gtu_pkg::IDX_AUX_B;
         3: order = gtu_pkg::IDX_CORE2;
         default: order = gtu_pkg::IDX_AUX2;
      endcase
   endfunction

   function automatic logic is_reg(input logic [7:0] a, input logic [7:0] base, input int n);
      is_reg = (a >= base) && (a < base + 8'(4 * n)) && (a[1:0] == 2'h0);
   endfunction

   // ---------------------------------------------------------------
   // pin synchronisers: tin[4:0], g1 dir[7:5], core2 dir 8, capture_input_pin 9
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         sync1_r <= '0;
         sync2_r <= '0;
         prev_r <= '0;
      end else begin
         sync1_r <= {capture_input_pin_i, core2_dir_i, g1_dir_i, tin_i};
         sync2_r <= sync1_r;
         prev_r <= sync2_r;
      end
   end

   // ---------------------------------------------------------------
   // prescaler, shared by both groups
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         pre_r <= '0;
      end else begin
         pre_r <= pre_r + 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // counting, capture and reload
   // ---------------------------------------------------------------
   always_comb begin
      logic [15:0] c;
      logic tick;
      logic down;
      logic pin_c;
      logic pin_p;
      logic dir_c;
      logic dir_p;
      logic pedge;
      logic trig;
      logic cap_ev;
      logic cnt_en;
      logic [1:0] cedge;
      logic cap_pin;
      logic cap_cin;
      logic cap_dir;
      int i;
      c = '0;
      tick = 1'b0;
      down = 1'b0;
      pin_c = 1'b0;
      pin_p = 1'b0;
      dir_c = 1'b0;
      dir_p = 1'b0;
      pedge = 1'b0;
      trig = 1'b0;
      cap_ev = 1'b0;
      cnt_en = 1'b0;
      cedge = 2'h0;
      cap_pin = 1'b0;
      cap_cin = 1'b0;
      cap_dir = 1'b0;
      i = 0;
      ovf = '0;
      stat_set = '0;
      l1_rise = 1'b0;
      l1_fall = 1'b0;
      l2_ev = 1'b0;
      capture_reload_register_nxt = capture_reload_register_r;
      for (int n = 0; n < gtu_pkg::NUM_TMR; n++) begin
         val_nxt[n] = val_r[n];
      end
      for (int k = 0; k < gtu_pkg::NUM_TMR; k++) begin
         i = order(k);
         c = ctrl_r[i];
         pin_c = sync2_r[i];
         pin_p = prev_r[i];
         if (i < 3) begin
            dir_c = sync2_r[5 + i];
            dir_p = prev_r[5 + i];
         end else if (i == gtu_pkg::IDX_CORE2) begin
            dir_c = sync2_r[8];
            dir_p = prev_r[8];
         end else begin
            dir_c = 1'b0;
            dir_p = 1'b0;
         end
         pedge = edge_hit(c[gtu_pkg::F_EDGE_MSB:gtu_pkg::F_EDGE_LSB], pin_p, pin_c);
         down = c[gtu_pkg::F_DOWN] ^ (c[gtu_pkg::F_EXTDIR] & dir_c);
         if (i < 3) begin
            tick = pre_hit(pre_r, c[gtu_pkg::F_PRE_MSB:gtu_pkg::F_PRE_LSB],
                           gtu_pkg::G1_BASE_SH);
         end else begin
            tick = pre_hit(pre_r, c[gtu_pkg::F_PRE_MSB:gtu_pkg::F_PRE_LSB],
                           gtu_pkg::G2_BASE_SH);
         end
         case (c[gtu_pkg::F_MODE_MSB:gtu_pkg::F_MODE_LSB])
            gtu_pkg::GTU_MODE_TIMER: begin
            end
            gtu_pkg::GTU_MODE_GATED: begin
               tick = tick & (pin_c == c[gtu_pkg::F_GATE]);
            end
            gtu_pkg::GTU_MODE_COUNT: begin
               tick = pedge;
            end
            default: begin
               if (i < 3) begin
                  // any A/B change counts, direction from phase
                  tick = (pin_c ^ pin_p) | (dir_c ^ dir_p);
                  down = c[gtu_pkg::F_DOWN] ^ ~(pin_p ^ dir_c);
               end else begin
                  tick = pedge;
               end
            end
         endcase
         if (c[gtu_pkg::F_LSRC]) begin
            if (i == gtu_pkg::IDX_AUX_A || i == gtu_pkg::IDX_AUX_B) begin
               tick = edge_hit(c[gtu_pkg::F_EDGE_MSB:gtu_pkg::F_EDGE_LSB], l1_fall, l1_rise);
            end else if (i == gtu_pkg::IDX_AUX2) begin
               tick = l2_ev;
            end
         end
         // auxiliary timer used as capture/reload register is held
         cnt_en = c[gtu_pkg::F_RUN] & tick;
         if ((i == gtu_pkg::IDX_AUX_A || i == gtu_pkg::IDX_AUX_B) &&
             c[gtu_pkg::F_FUNC_MSB:gtu_pkg::F_FUNC_LSB] != gtu_pkg::GTU_FN_NORMAL) begin
            cnt_en = 1'b0;
         end
         if (cnt_en) begin
            if (down) begin
               val_nxt[i] = val_r[i] - 16'h0001;
               ovf[i] = (val_r[i] == 16'h0000);
            end else begin
               val_nxt[i] = val_r[i] + 16'h0001;
               ovf[i] = (val_r[i] == 16'hffff);
            end
         end
         if (i == gtu_pkg::IDX_CORE1) begin
            l1_rise = ovf[i] & ~latch1_r;
            l1_fall = ovf[i] & latch1_r;
         end
         if (i == gtu_pkg::IDX_CORE2) begin
            l2_ev = ovf[i];
            if (ovf[i] && c[gtu_pkg::F_RLD_CR]) begin
               val_nxt[i] = capture_reload_register_r;
            end
         end
         if (i == gtu_pkg::IDX_AUX_A || i == gtu_pkg::IDX_AUX_B) begin
            if (c[gtu_pkg::F_FUNC_MSB:gtu_pkg::F_FUNC_LSB] == gtu_pkg::GTU_FN_RELOAD) begin
               trig = c[gtu_pkg::F_RLD_LATCH] ?
                      edge_hit(c[gtu_pkg::F_EDGE_MSB:gtu_pkg::F_EDGE_LSB], l1_fall, l1_rise) :
                      pedge;
               if (trig) begin
                  val_nxt[gtu_pkg::IDX_CORE1] = val_r[i];
               end
            end else if (c[gtu_pkg::F_FUNC_MSB:gtu_pkg::F_FUNC_LSB] == gtu_pkg::GTU_FN_CAPTURE &&
                         pedge) begin
               val_nxt[i] = val_r[gtu_pkg::IDX_CORE1];
               stat_set[i == 0 ? gtu_pkg::S_CAP_A : gtu_pkg::S_CAP_B] = 1'b1;
            end
         end
      end
      // capture sources of the capture/reload register
      cedge = ctrl_r[gtu_pkg::IDX_CORE2][gtu_pkg::F_CEDGE_MSB:gtu_pkg::F_CEDGE_LSB];
      cap_pin = ctrl_r[gtu_pkg::IDX_AUX2][gtu_pkg::F_CAP_PIN] &
                edge_hit(cedge, prev_r[9], sync2_r[9]);
      cap_cin = ctrl_r[gtu_pkg::IDX_AUX2][gtu_pkg::F_CAP_T1IN] &
                edge_hit(cedge, prev_r[1], sync2_r[1]);
      cap_dir = ctrl_r[gtu_pkg::IDX_AUX2][gtu_pkg::F_CAP_T1DIR] &
                edge_hit(cedge, prev_r[6], sync2_r[6]);
      cap_ev = cap_pin | cap_cin | cap_dir;
      if (cap_ev) begin
         capture_reload_register_nxt = val_r[gtu_pkg::IDX_AUX2];
         stat_set[gtu_pkg::S_CAP_CR] = 1'b1;
         if (ctrl_r[gtu_pkg::IDX_AUX2][gtu_pkg::F_CLR]) begin
            val_nxt[gtu_pkg::IDX_AUX2] = gtu_pkg::VAL_RST;
         end
      end
      stat_set[gtu_pkg::NUM_TMR-1:0] = stat_set[gtu_pkg::NUM_TMR-1:0] | ovf;
   end

   // ---------------------------------------------------------------
   // control registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         for (int n = 0; n < gtu_pkg::NUM_TMR; n++) begin
            ctrl_r[n] <= gtu_pkg::CTRL_RST;
         end
      end else begin
         for (int n = 0; n < gtu_pkg::NUM_TMR; n++) begin
            if (wr_i && addr_i == gtu_pkg::CTRL_BASE + 8'(4 * n)) begin
               ctrl_r[n] <= wdata_i;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // timer values
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         for (int n = 0; n < gtu_pkg::NUM_TMR; n++) begin
            val_r[n] <= gtu_pkg::VAL_RST;
         end
         capture_reload_register_r <= gtu_pkg::VAL_RST;
      end else begin
         capture_reload_register_r <= capture_reload_register_nxt;
         for (int n = 0; n < gtu_pkg::NUM_TMR; n++) begin
            val_r[n] <= val_nxt[n];
            if (wr_i && addr_i == gtu_pkg::VAL_BASE + 8'(4 * n)) begin
               val_r[n] <= wdata_i;
            end
         end
         if (wr_i && addr_i == gtu_pkg::CAPTURE_RELOAD_REGISTER_OFS) begin
            capture_reload_register_r <= wdata_i;
         end
      end
   end

   // ---------------------------------------------------------------
   // toggle latches and compare clock
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         latch1_r <= 1'b0;
         latch2_r <= 1'b0;
         core1_tout_o <= 1'b0;
         core2_tout_o <= 1'b0;
         cmp_clk_o <= 1'b0;
      end else begin
         latch1_r <= latch1_r ^ ovf[gtu_pkg::IDX_CORE1];
         latch2_r <= latch2_r ^ ovf[gtu_pkg::IDX_CORE2];
         core1_tout_o <= ctrl_r[gtu_pkg::IDX_CORE1][gtu_pkg::F_TOUT] &
                         (latch1_r ^ ovf[gtu_pkg::IDX_CORE1]);
         core2_tout_o <= ctrl_r[gtu_pkg::IDX_CORE2][gtu_pkg::F_TOUT] &
                         (latch2_r ^ ovf[gtu_pkg::IDX_CORE2]);
         cmp_clk_o <= ovf[gtu_pkg::IDX_CORE2];
      end
   end

   // ---------------------------------------------------------------
   // status flags: write one to clear, set wins
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         stat_r <= '0;
      end else if (wr_i && addr_i == gtu_pkg::STAT_OFS) begin
         stat_r <= (stat_r & ~wdata_i[gtu_pkg::STAT_W-1:0]) | stat_set;
      end else begin
         stat_r <= stat_r | stat_set;
      end
   end

   // ---------------------------------------------------------------
   // read port
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rdata_o <= '0;
      end else if (rd_i) begin
         if (is_reg(addr_i, gtu_pkg::CTRL_BASE, gtu_pkg::NUM_TMR)) begin
            rdata_o <= ctrl_r[3'((addr_i - gtu_pkg::CTRL_BASE) >> 2)];
         end else if (is_reg(addr_i, gtu_pkg::VAL_BASE, gtu_pkg::NUM_TMR)) begin
            rdata_o <= val_r[3'((addr_i - gtu_pkg::VAL_BASE) >> 2)];
         end else if (addr_i == gtu_pkg::CAPTURE_RELOAD_REGISTER_OFS) begin
            rdata_o <= capture_reload_register_r;
         end else if (addr_i == gtu_pkg::STAT_OFS) begin
            rdata_o <= {8'h00, stat_r};
         end else if (addr_i == gtu_pkg::LATCH_OFS) begin
            rdata_o <= {14'h0000, latch2_r, latch1_r};
         end else begin
            rdata_o <= '0;
         end
      end else begin
         rdata_o <= '0;
      end
   end
endmodule

// ---- gtu_timer_unit_assertions.sv ----
`timescale 1ns/1ps
module gtu_chk (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // register port
   input wire logic [7:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [15:0] rdata_o,
   // outputs
   input wire logic core1_tout_o,
   input wire logic core2_tout_o,
   input wire logic cmp_clk_o
);
   // --------
   // shadows of software settings
   // --------
   logic [15:0] ctl0_r;
   logic en1_r;
   logic en2_r;
   logic run2_r;
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ctl0_r <= 16'h0000;
         en1_r <= 1'b0;
         en2_r <= 1'b0;
         run2_r <= 1'b0;
      end else if (wr_i) begin
         if (addr_i == 8'h00) begin
            ctl0_r <= wdata_i;
         end
         if (addr_i == 8'h04) begin
            en1_r <= wdata_i[gtu_pkg::F_TOUT];
         end
         if (addr_i == 8'h10) begin
            en2_r <= wdata_i[gtu_pkg::F_TOUT];
            run2_r <= wdata_i[gtu_pkg::F_RUN];
         end
      end
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   // --------
   // checks
   // --------
   rd_idle_a: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
      else $error("read data outside read slot");
   ctl_back_a: assert property (rd_i && addr_i == 8'h00 |=> rdata_o == $past(ctl0_r))
      else $error("control readback differs");
   unmap_a: assert property (rd_i && addr_i > 8'h48 |=> rdata_o == 16'h0000)
      else $error("unmapped read not zero");
   rst_out_a: assert property (disable iff (1'b0) !rst_n_i |=> !core1_tout_o
      && !core2_tout_o && !cmp_clk_o && rdata_o == 16'h0000)
      else $error("outputs active after reset");
   tout1_gate_a: assert property (!en1_r && !$past(en1_r) && !$past(en1_r, 2)
      |-> !core1_tout_o)
      else $error("core one toggle out while disabled");
   tout2_gate_a: assert property (!en2_r && !$past(en2_r) && !$past(en2_r, 2)
      |-> !core2_tout_o)
      else $error("core two toggle out while disabled");
   cmp_idle_a: assert property (!run2_r && !$past(run2_r) && !$past(run2_r, 2)
      |-> !cmp_clk_o)
      else $error("compare clock while core two stopped");
   cmp_pulse_a: assert property (cmp_clk_o |=> !cmp_clk_o)
      else $error("compare clock pulses too close");
   tout2_sync_a: assert property ($changed(core2_tout_o) && !$past(wr_i)
      && !$past(wr_i, 2) |-> (cmp_clk_o || $past(cmp_clk_o)) or ##1 cmp_clk_o)
      else $error("core two toggle without wrap");
   cover property (cmp_clk_o);
   cover property ($rose(core1_tout_o));
   cover property (rd_i && addr_i == 8'h40);
endmodule

// ---- tb_gtu_timer_unit.sv ----
`timescale 1ns/1ps
module tb_gtu_timer_unit;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [15:0] wdata_i = 16'h0000;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [15:0] rdata_o;
   logic [4:0] tin_i;
   logic [2:0] g1_dir_i;
   logic core2_dir_i;
   logic capture_input_pin_i;
   logic core1_tout_o;
   logic core2_tout_o;
   logic cmp_clk_o;
   int err_count = 0;
   int cmp_count = 0;
   int n;
   logic [15:0] v0;
   logic [15:0] v1;
   logic [15:0] v2;
   int t_idx[8] = '{0, 1, 2, 0, 2, 2, 3, 4};
   logic [15:0] t_ctl[8] = '{16'h0100, 16'h0101, 16'h0300, 16'h0500,
      16'h0188, 16'h0188, 16'h0500, 16'h0302};
   logic [4:0] t_pin[8] = '{5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h04, 5'h00, 5'h00};
   logic [2:0] t_dir[8] = '{3'h0, 3'h0, 3'h0, 3'h1, 3'h0, 3'h0, 3'h7, 3'h0};
   logic [15:0] t_exp[8] = '{16'h000a, 16'h0005, 16'hfff6, 16'hfff6,
      16'h0000, 16'h000a, 16'h0014, 16'hfffb};
   initial begin
      forever #12.5 clk_i = ~clk_i;
   end
   gtu_timer_unit uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .tin_i(tin_i),
      .g1_dir_i(g1_dir_i), .core2_dir_i(core2_dir_i), .capture_input_pin_i(capture_input_pin_i),
      .core1_tout_o(core1_tout_o), .core2_tout_o(core2_tout_o), .cmp_clk_o(cmp_clk_o));
   gtu_pin_model pins (.clk_i(clk_i), .tin_o(tin_i), .dir_o(g1_dir_i),
      .core2_dir_o(core2_dir_i), .capture_input_pin_o(capture_input_pin_i));
   // --------
   // access and checking tasks
   // --------
   task automatic final_report();
      $display("checks %0d errors %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask
   // cycles until the selected toggle output changes
   task automatic run_len(input bit s, output int len);
      logic lvl;
      lvl = s ? core2_tout_o : core1_tout_o;
      len = 0;
      while ((s ? core2_tout_o : core1_tout_o) === lvl && len < 3000) begin
         @(posedge clk_i);
         #1;
         len++;
      end
      if (len >= 3000) begin
         err_count++;
         $display("Error toggle exp change seen none");
         final_report();
      end
   endtask
   // --------
   // scenarios
   // --------
   initial begin
      repeat (4) @(posedge clk_i);
      rst_n_i <= 1'b1;
      for (int i = 0; i < 20; i++) begin
         rd(8'(4 * i), v0);
         chk("reset value", v0, 16'h0000);
      end
      for (int i = 0; i < 8; i++) begin
         pins.set_lvl(t_pin[i], t_dir[i], t_dir[i][2]);
         wr(8'(4 * t_idx[i]), t_ctl[i]);
         repeat (6) @(posedge clk_i);
         rd(8'h20 + 8'(4 * t_idx[i]), v0);
         repeat (38) @(posedge clk_i);
         rd(8'h20 + 8'(4 * t_idx[i]), v1);
         chk("rate", v1 - v0, t_exp[i]);
         wr(8'(4 * t_idx[i]), 16'h0000);
      end
      for (int e = 1; e < 4; e++) begin
         wr(8'h20, 16'h0000);
         wr(8'h00, 16'h0110 | 16'(e << 5));
         repeat (3) pins.pulse(0);
         wr(8'h00, 16'h0000);
         rd(8'h20, v0);
         chk("events", v0, (e == 3) ? 16'h0006 : 16'h0003);
      end
      wr(8'h24, 16'h0000);
      wr(8'h04, 16'h0118);
      repeat (4) pins.step(1);
      rd(8'h24, v0);
      chk("position fwd", v0, 16'hfffc);
      repeat (4) pins.step(-1);
      rd(8'h24, v0);
      chk("position back", v0, 16'h0000);
      wr(8'h00, 16'h2120);
      wr(8'h04, 16'h0100);
      rd(8'h24, v0);
      pins.pulse(0);
      rd(8'h20, v1);
      rd(8'h24, v2);
      chk("capture", 16'(v1 > v0 && v1 <= v2), 16'h0001);
      repeat (20) @(posedge clk_i);
      rd(8'h20, v2);
      chk("capture hold", v2, v1);
      rd(8'h44, v0);
      chk("capture flag", v0 & 16'h0020, 16'h0020);
      wr(8'h04, 16'h0000);
      wr(8'h44, 16'h00ff);
      rd(8'h44, v0);
      chk("flag clear", v0, 16'h0000);
      wr(8'h20, 16'hfff0);
      wr(8'h28, 16'hffe0);
      wr(8'h00, 16'h9020);
      wr(8'h08, 16'h9040);
      wr(8'h24, 16'hfff8);
      wr(8'h04, 16'h0900);
      run_len(1'b0, n);
      run_len(1'b0, n);
      chk("pwm high", 16'(n), 16'd64);
      run_len(1'b0, n);
      chk("pwm low", 16'(n), 16'd128);
      wr(8'h40, 16'hfff0);
      wr(8'h30, 16'hfff8);
      wr(8'h10, 16'h1900);
      // latch is already set: enable edge, then a part period, then full ones
      run_len(1'b1, n);
      run_len(1'b1, n);
      run_len(1'b1, n);
      chk("core two period", 16'(n), 16'd32);
      v0 = 16'h0000;
      repeat (64) begin
         @(posedge clk_i);
         #1;
         v0 = v0 + 16'(cmp_clk_o);
      end
      chk("compare clock", v0, 16'h0002);
      wr(8'h10, 16'h2000);
      wr(8'h44, 16'h00ff);
      wr(8'h2c, 16'h0000);
      wr(8'h0c, 16'h3900);
      repeat (30) @(posedge clk_i);
      pins.pulse(5);
      rd(8'h40, v0);
      rd(8'h2c, v1);
      chk("capture_reload_register clear", 16'(v0 > 16'h000f && v1 < v0), 16'h0001);
      rd(8'h44, v0);
      chk("capture_reload_register flag", v0 & 16'h0080, 16'h0080);
      wr(8'h44, 16'h00ff);
      pins.pulse(1);
      rd(8'h44, v0);
      chk("pin source", v0 & 16'h0080, 16'h0080);
      final_report();
   end
endmodule
bind gtu_timer_unit gtu_chk u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .core1_tout_o(core1_tout_o), .core2_tout_o(core2_tout_o), .cmp_clk_o(cmp_clk_o));
